// ==== core/height_display_map.svh ====
/*
 * Constants of the height display relay sequencer: timing, register
 * offsets, field positions and reset values.
 * Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
`ifndef HEIGHT_DISPLAY_MAP_SVH
`define HEIGHT_DISPLAY_MAP_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define HD_CLK_MHZ 100
`define HD_DEBOUNCE_US 1000
`define HD_DEBOUNCE_CYCLES ((`HD_DEBOUNCE_US) * (`HD_CLK_MHZ))
`define HD_CLEAR_US 10
`define HD_CLEAR_CYCLES ((`HD_CLEAR_US) * (`HD_CLK_MHZ))

// ---------------------------------------------------------------
// Input vector positions and idle levels
// ---------------------------------------------------------------
`define HD_IN_COUNT 4
`define HD_IN_GRANT 0
`define HD_IN_CLEAR_LINE_N 1
`define HD_IN_CLEAR_SWITCH 2
`define HD_IN_REQUEST 3
`define HD_IN_RESET 4'h2

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define HD_CTRL_OFFSET 12'h000
`define HD_STATUS_OFFSET 12'h004
`define HD_CTRL_SOFT_CLEAR 0
`define HD_CTRL_GRANT_CLEAR_EN 1
`define HD_CTRL_SWITCH_EN 2
`define HD_CTRL_RESET 3'h6
`define HD_ST_FOLLOWER 0
`define HD_ST_LATCH 1
`define HD_ST_HOLD 2
`define HD_ST_CLEARING 3
`define HD_ST_GRANT 4
`define HD_ST_BRAKE 5
`define HD_ST_TRACKING 6
`define HD_RESP_OKAY 2'h0
`define HD_RESP_SLVERR 2'h2

`endif

// ==== core/height_display_pkg.sv ====
/*
 * Types of the height display relay sequencer.
 * Assumes the constants of height_display_map.svh.
 */
package height_display_pkg;

    // Relay states held as registered bits
    typedef struct packed {
        logic request_follower_relay;
        logic relative_mode_latch;
        logic hold_relay;
    } relay_s;

    // Outputs toward the display panel and servos
    typedef struct packed {
        logic brake_solenoid;
        logic absolute_tracking_en;
        logic relative_height_follower;
        logic absolute_dial_lamp;
        logic relative_dial_lamp;
    } panel_s;

    // Register selected by a bus address
    typedef enum logic [1:0] {
        SEL_CTRL,
        SEL_STATUS,
        SEL_NONE
    } reg_sel_e;

endpackage

// ==== core/input_filter.sv ====
/*
 * Synchroniser and debouncer for one switch or line input.
 * Assumes the raw level may change at any time; the output changes only
 * after the synchronised level has stood for STABLE_CYCLES clocks.
 */
`timescale 1ns/100ps
`default_nettype none

module input_filter #(
    parameter int unsigned STABLE_CYCLES = 100000,
    parameter bit RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Levels
    input wire logic raw,
    output var logic clean
);

    localparam int CNT_W = $clog2(STABLE_CYCLES + 1);

    logic sync1;
    logic sync2;
    logic [CNT_W-1:0] count;

    // Two-stage synchroniser; only sync2 reads sync1
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= RESET_VAL;
            sync2 <= RESET_VAL;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    // Accept a new level once it has stood long enough
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            clean <= RESET_VAL;
        end else if (sync2 == clean) begin
            count <= '0;
        end else if (count == CNT_W'(STABLE_CYCLES - 1)) begin
            count <= '0;
            clean <= sync2;
        end else begin
            count <= count + CNT_W'(1);
        end
    end

endmodule

`default_nettype wire

// ==== core/height_display_relay_sequencer.sv ====
/*
 * Relay sequencer of one remote height display station, with an AXI4-Lite
 * register slave for control and status.
 * Assumes a single 100 MHz clock, switch and line inputs that may bounce,
 * and a bus master with at most one write and one read under way.
 */
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "height_display_map.svh"

module height_display_relay_sequencer #(
    parameter int unsigned DEBOUNCE_CYCLES = `HD_DEBOUNCE_CYCLES,
    parameter int unsigned CLEAR_CYCLES = `HD_CLEAR_CYCLES,
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Station inputs
    input wire logic grant,
    input wire logic clear_line_n,
    input wire logic station_clear_switch,
    input wire logic handcrank_request_switch,
    // Station outputs
    output var logic clear_hold_n,
    output var height_display_pkg::panel_s panel,
    // AXI4-Lite write address channel
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data channel
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response channel
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output var logic [1:0] s_axi_bresp,
    // AXI4-Lite read address channel
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data channel
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp
);

    localparam int CLEAR_W = $clog2(CLEAR_CYCLES + 1);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [`HD_IN_COUNT-1:0] raw_in;
    logic [`HD_IN_COUNT-1:0] clean_in;
    logic grant_q;
    logic [CLEAR_W-1:0] clear_cnt;
    logic clearing;
    height_display_pkg::relay_s relay;
    logic [2:0] ctrl;
    logic soft_clear;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    logic grant_rise;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------

    // Map a byte address onto a register
    function automatic height_display_pkg::reg_sel_e decode(
        input logic [ADDR_W-1:0] addr
    );
        height_display_pkg::reg_sel_e sel;
        sel = height_display_pkg::SEL_NONE;
        if (addr == ADDR_W'(`HD_CTRL_OFFSET)) begin
            sel = height_display_pkg::SEL_CTRL;
        end else if (addr == ADDR_W'(`HD_STATUS_OFFSET)) begin
            sel = height_display_pkg::SEL_STATUS;
        end
        return sel;
    endfunction

    // ---------------------------------------------------------------
    // Input conditioning
    // ---------------------------------------------------------------

    // Gather the raw station inputs into one vector
    assign raw_in[`HD_IN_GRANT] = grant;
    assign raw_in[`HD_IN_CLEAR_LINE_N] = clear_line_n;
    assign raw_in[`HD_IN_CLEAR_SWITCH] = station_clear_switch;
    assign raw_in[`HD_IN_REQUEST] = handcrank_request_switch;

    // One synchroniser and debouncer per input
    for (genvar i = 0; i < `HD_IN_COUNT; i++) begin : g_filter
        input_filter #(
            .STABLE_CYCLES(DEBOUNCE_CYCLES),
            .RESET_VAL(1'(`HD_IN_RESET >> i))
        ) u_filter (
            .core_clk(core_clk),
            .nrst(nrst),
            .raw(raw_in[i]),
            .clean(clean_in[i])
        );
    end

    // ---------------------------------------------------------------
    // Clear pulse generation
    // ---------------------------------------------------------------

    // Remember the grant level to catch its arrival
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            grant_q <= 1'b0;
        end else begin
            grant_q <= clean_in[`HD_IN_GRANT];
        end
    end

    assign grant_rise = clean_in[`HD_IN_GRANT] && !grant_q;

    // Load the clear timer on a new grant or a software clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clear_cnt <= '0;
        end else if ((grant_rise && ctrl[`HD_CTRL_GRANT_CLEAR_EN])
                     || soft_clear) begin
            clear_cnt <= CLEAR_W'(CLEAR_CYCLES);
        end else if (clear_cnt != '0) begin
            clear_cnt <= clear_cnt - CLEAR_W'(1);
        end
    end

    // Drive the clear line low while the timer runs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clear_hold_n <= 1'b1;
        end else begin
            clear_hold_n <= (clear_cnt == '0);
        end
    end

    // Any break of the holding path: own pulse, line or switch
    assign clearing = !clear_hold_n
                      || !clean_in[`HD_IN_CLEAR_LINE_N]
                      || (clean_in[`HD_IN_CLEAR_SWITCH]
                          && ctrl[`HD_CTRL_SWITCH_EN]);

    // ---------------------------------------------------------------
    // Relay states
    // ---------------------------------------------------------------

    // Follower tracks the request line directly
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            relay.request_follower_relay <= 1'b0;
        end else begin
            relay.request_follower_relay <=
                clean_in[`HD_IN_REQUEST];
        end
    end

    // Latch sets from the follower and holds until the path breaks
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            relay.relative_mode_latch <= 1'b0;
        end else if (clearing) begin
            relay.relative_mode_latch <= 1'b0;
        end else if (relay.request_follower_relay) begin
            relay.relative_mode_latch <= 1'b1;
        end
    end

    // Hold follows the latch once the follower has dropped
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            relay.hold_relay <= 1'b0;
        end else begin
            relay.hold_relay <= relay.relative_mode_latch
                                && !relay.request_follower_relay;
        end
    end

    // ---------------------------------------------------------------
    // Panel outputs
    // ---------------------------------------------------------------

    // Brake, tracking, follower excitation and dial lamps
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            panel <= '0;
        end else begin
            panel.brake_solenoid <= clean_in[`HD_IN_GRANT]
                                    && !relay.hold_relay;
            panel.absolute_tracking_en <=
                !relay.relative_mode_latch;
            panel.absolute_dial_lamp <= relay.relative_mode_latch;
            panel.relative_height_follower <= !relay.hold_relay;
            panel.relative_dial_lamp <= relay.hold_relay;
        end
    end

    // ---------------------------------------------------------------
    // Register write path
    // ---------------------------------------------------------------

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    // Take the write address once, then wait for the response
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
            wr_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
            wr_addr <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    // Take the write data once, then wait for the response
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // Response once both halves are held
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HD_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (decode(wr_addr) == height_display_pkg::SEL_NONE) begin
                s_axi_bresp <= `HD_RESP_SLVERR;
            end else begin
                s_axi_bresp <= `HD_RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control bits; the soft clear bit acts for one cycle only
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= `HD_CTRL_RESET;
            soft_clear <= 1'b0;
        end else begin
            soft_clear <= 1'b0;
            if (wr_fire && wr_strb[0]
                && decode(wr_addr) == height_display_pkg::SEL_CTRL) begin
                ctrl <= {wr_data[`HD_CTRL_SWITCH_EN],
                         wr_data[`HD_CTRL_GRANT_CLEAR_EN], 1'b0};
                soft_clear <= wr_data[`HD_CTRL_SOFT_CLEAR];
            end
        end
    end

    // ---------------------------------------------------------------
    // Register read path
    // ---------------------------------------------------------------

    // Answer one read at a time, one cycle after the address
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `HD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= '0;
            s_axi_rresp <= `HD_RESP_OKAY;
            case (decode(s_axi_araddr))
                height_display_pkg::SEL_CTRL: begin
                    s_axi_rdata[2:0] <= ctrl;
                end
                height_display_pkg::SEL_STATUS: begin
                    s_axi_rdata[`HD_ST_FOLLOWER] <=
                        relay.request_follower_relay;
                    s_axi_rdata[`HD_ST_LATCH] <= relay.relative_mode_latch;
                    s_axi_rdata[`HD_ST_HOLD] <= relay.hold_relay;
                    s_axi_rdata[`HD_ST_CLEARING] <= clearing;
                    s_axi_rdata[`HD_ST_GRANT] <= clean_in[`HD_IN_GRANT];
                    s_axi_rdata[`HD_ST_BRAKE] <= panel.brake_solenoid;
                    s_axi_rdata[`HD_ST_TRACKING] <=
                        panel.absolute_tracking_en;
                end
                default: begin
                    s_axi_rresp <= `HD_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// ==== tb/height_display_checker_properties.sv ====
/*
 * Port checker of the height display relay sequencer.
 * Assumes it is bound into the sequencer and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none

module height_display_checker #(
    parameter int unsigned CLEAR_CYCLES = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Station
    input wire logic grant,
    input wire logic clear_hold_n,
    input wire height_display_pkg::panel_s panel,
    // Read channels
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    int unsigned low_cnt;

    // Counts cycles of the own clear line held low
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) low_cnt <= 0;
        else if (!clear_hold_n) low_cnt <= low_cnt + 1;
        else low_cnt <= 0;
    end

    property p_brake_hold;
        panel.brake_solenoid |-> !panel.relative_dial_lamp;
    endproperty
    a_brake_hold: assert property (p_brake_hold)
        else $error("brake released while hold lamp lit");
    property p_brake_grant;
        $rose(panel.brake_solenoid) |-> grant;
    endproperty
    a_brake_grant: assert property (p_brake_grant)
        else $error("brake released without grant");
    property p_clear_on_grant;
        $rose(grant) |-> ##[1:30] !clear_hold_n;
    endproperty
    a_clear_on_grant: assert property (p_clear_on_grant)
        else $error("no clear after new grant");
    property p_clear_width;
        $rose(clear_hold_n) |-> low_cnt == CLEAR_CYCLES;
    endproperty
    a_clear_width: assert property (p_clear_width)
        else $error("clear pulse has wrong width");
    property p_clear_effect;
        $fell(clear_hold_n) |-> ##[1:4] (!panel.absolute_dial_lamp &&
            !panel.relative_dial_lamp && panel.absolute_tracking_en);
    endproperty
    a_clear_effect: assert property (p_clear_effect)
        else $error("clear pulse left station set");
    property p_abs_lamp;
        panel.absolute_dial_lamp |-> !panel.absolute_tracking_en;
    endproperty
    a_abs_lamp: assert property (p_abs_lamp)
        else $error("tracking on with latch set");
    property p_hold_outputs;
        panel.relative_dial_lamp |->
            !panel.relative_height_follower && !panel.brake_solenoid;
    endproperty
    a_hold_outputs: assert property (p_hold_outputs)
        else $error("hold lamp without follower off");
    property p_hold_after_latch;
        $rose(panel.relative_dial_lamp) |-> $past(panel.absolute_dial_lamp);
    endproperty
    a_hold_after_latch: assert property (p_hold_after_latch)
        else $error("hold set without latch");
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered next cycle");

    // Main scenarios reached
    c_grant_clear: cover property ($rose(grant) ##[1:30] !clear_hold_n);
    c_hold: cover property ($rose(panel.relative_dial_lamp));
    c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule

bind height_display_relay_sequencer height_display_checker #(
    .CLEAR_CYCLES(CLEAR_CYCLES)
) height_display_checker_inst (
    .core_clk(core_clk),
    .nrst(nrst),
    .grant(grant),
    .clear_hold_n(clear_hold_n),
    .panel(panel),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

// ==== tb/height_station_partner.sv ====
/*
 * Model of the time-sharing controller and far operator station.
 * Assumes the bench asks for grant and handcrank by two levels.
 */
`timescale 1ns/100ps
`default_nettype none

module height_station_partner (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Requests of the bench
    input wire logic want_grant,
    input wire logic want_crank,
    // Station lines
    output var logic grant,
    output var logic clear_line_n,
    output var logic handcrank_request_switch
);
    logic [3:0] gap;

    // Grant with a clear pulse at each new grant, crank passed through
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            grant <= 1'b0;
            clear_line_n <= 1'b1;
            gap <= 4'h0;
            handcrank_request_switch <= 1'b0;
        end else begin
            grant <= want_grant;
            if (want_grant && !grant) gap <= 4'hC;
            else if (gap != 4'h0) gap <= gap - 4'h1;
            clear_line_n <= (gap == 4'h0);
            handcrank_request_switch <= want_crank;
        end
    end
endmodule
`default_nettype wire

// ==== tb/height_display_relay_sequencer_bench.sv ====
/*
 * Self-checking bench of the height display relay sequencer.
 * Assumes short debounce and clear counts and the partner model.
 */
`timescale 1ns/100ps
`default_nettype none
`include "height_display_map.svh"

module height_display_relay_sequencer_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic core_clk = 1'b0, nrst = 1'b0, want_grant = 1'b0;
    logic want_crank = 1'b0, station_clear_switch = 1'b0;
    logic grant, clear_line_n, handcrank_request_switch, clear_hold_n;
    height_display_pkg::panel_s panel;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] rd;
    logic [5:0] plan [9] = '{6'h00, 6'h20, 6'h36, 6'h23, 6'h03,
        6'h08, 6'h16, 6'h03, 6'h20};
    int failures = 0, comparisons = 0;
    logic [31:0] seed = 32'd5772;

    always #5 core_clk = ~core_clk;

    height_display_relay_sequencer #(.DEBOUNCE_CYCLES(4), .CLEAR_CYCLES(5))
        height_display_relay_sequencer_inst (.*);
    height_station_partner height_station_partner_inst (.*);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Panel from latch, hold and grant
    function automatic logic [31:0] panel_of(logic l, logic h, logic g);
        return {27'h0, g & !h, !l, !h, l, h};
    endfunction
    // Status word from the relay states and a standing clear
    function automatic logic [31:0] status_of(logic f, l, h, g, c);
        return {25'h0, !l, g & !h, g, c, h, l, f};
    endfunction
    task automatic check(string what, logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic axi_write(logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        check("write answer", 32'(s_axi_bvalid), 32'h1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(logic [11:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        check("read answer", 32'(s_axi_rvalid), 32'h1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic settle();
        repeat (30 + next_rand() % 16) @(posedge core_clk);
    endtask
    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #100000;
        failures++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        axi_read(`HD_CTRL_OFFSET);
        check("ctrl reset", rd, 32'h6);
        // Rows: grant, crank, switch, then follower, latch, hold
        for (int i = 0; i < 9; i++) begin
            want_grant <= plan[i][5];
            want_crank <= plan[i][4];
            station_clear_switch <= plan[i][3];
            settle();
            check("panel", 32'(panel), panel_of(plan[i][1], plan[i][0],
                plan[i][5]));
            axi_read(`HD_STATUS_OFFSET);
            check("status", rd, status_of(plan[i][2], plan[i][1],
                plan[i][0], plan[i][5], plan[i][3]));
            $display("test %0d done", i);
        end
        // Short random glitches on the crank are filtered out
        for (int k = 0; k < 4; k++) begin
            want_crank <= 1'b1;
            repeat (1 + next_rand() % 3) @(posedge core_clk);
            want_crank <= 1'b0;
            repeat (6 + next_rand() % 8) @(posedge core_clk);
        end
        settle();
        check("glitch", 32'(panel), panel_of(0, 0, 1));
        $display("test glitch done");
        // Soft clear of a held station, then switch clear disabled
        want_crank <= 1'b1;
        settle();
        want_crank <= 1'b0;
        settle();
        axi_write(`HD_CTRL_OFFSET, 32'h7);
        settle();
        check("soft clear", 32'(panel), panel_of(0, 0, 1));
        axi_write(`HD_CTRL_OFFSET, 32'h2);
        axi_read(`HD_CTRL_OFFSET);
        check("ctrl", rd, 32'h2);
        want_crank <= 1'b1;
        settle();
        want_crank <= 1'b0;
        station_clear_switch <= 1'b1;
        settle();
        station_clear_switch <= 1'b0;
        check("switch off", 32'(panel), panel_of(1, 1, 1));
        $display("test ctrl done");
        // Unmapped places answer with an error
        axi_write(12'h0F0, 32'h1);
        check("wr resp", 32'(resp), 32'(`HD_RESP_SLVERR));
        axi_read(12'h0F0);
        check("rd resp", 32'(resp), 32'(`HD_RESP_SLVERR));
        axi_write(`HD_STATUS_OFFSET, 32'h0);
        axi_read(`HD_STATUS_OFFSET);
        check("status ro", rd, status_of(0, 1, 1, 1, 0));
        $display("test bus done");
        complete_run();
    end
endmodule
`default_nettype wire
